// file: hdl/lcdsd_dispmem.sv
// 32-byte display data memory of the segment lcd driver
`timescale 1ns/100ps
module lcdsd_dispmem import lcdsd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // write port
   input wire logic wr_en,
   input wire logic [DMEM_IDX_W-1:0] wr_index,
   input wire logic [7:0] wr_data,
   // read port
   input wire logic [DMEM_IDX_W-1:0] rd_index,
   output logic [7:0] rd_data,
   // whole array for the scanner
   output lcdsd_dmem_t mem_q
);

   // ==========================================================
   // state
   typedef struct packed {
      lcdsd_dmem_t mem;
   } lcdsd_dmem_state_t;

   lcdsd_dmem_state_t st_ff;
   lcdsd_dmem_state_t nxt_st;

   assign rd_data = st_ff.mem[rd_index];
   assign mem_q = st_ff.mem;

   always_comb
   begin
      nxt_st = st_ff;
      if (wr_en)
      begin
         nxt_st.mem[wr_index] = wr_data;
         if (wr_index <= DMEM_NIB_LAST)
            nxt_st.mem[wr_index][7:4] = 4'h0; // see [R8]
      end
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

endmodule

// file: hdl/lcdsd_pkg.sv
// constants, types and drive-level functions of the segment lcd driver
package lcdsd_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLOCK_HZ = 100_000_000;
   localparam int unsigned SLOT_TIME_US = 10;
   localparam int unsigned SLOT_CYCLES = (CLOCK_HZ / 1_000_000) * SLOT_TIME_US;
   localparam int unsigned SLOT_CNT_W = 10;
   localparam logic [SLOT_CNT_W-1:0] SLOT_LAST = SLOT_CNT_W'(SLOT_CYCLES - 1);
   localparam logic [SLOT_CNT_W-1:0] SLOT_CNT_RESET = 10'h000;

   // ==========================================================
   // geometry
   localparam int unsigned DMEM_BYTES = 32;
   localparam int unsigned DMEM_IDX_W = 5;
   localparam int unsigned COMMONS = 4;
   localparam int unsigned SEGMENTS = 32;
   localparam int unsigned SCAN_FIRST = 24;
   localparam int unsigned SCAN_SPLIT = 28;
   localparam logic [DMEM_IDX_W-1:0] DMEM_NIB_LAST = 5'h03;

   // ==========================================================
   // register addresses
   localparam logic [15:0] DMEM_BASE = 16'hfa40;
   localparam logic [15:0] DMEM_LAST = 16'hfa5f;
   localparam logic [15:0] CTRL_ADDR = 16'hfa60;
   localparam logic [15:0] SCAN_PORT_A_ADDR = 16'hfa61;
   localparam logic [15:0] SCAN_PORT_B_ADDR = 16'hfa62;
   localparam logic [15:0] STATUS_ADDR = 16'hfa63;

   // ==========================================================
   // control fields and reset values
   localparam int unsigned CTRL_SLOTS_LSB = 0;
   localparam int unsigned CTRL_SLOTS_W = 2;
   localparam int unsigned CTRL_BIAS_LSB = 2;
   localparam int unsigned CTRL_BIAS_W = 2;
   localparam int unsigned CTRL_EN_BIT = 4;
   localparam int unsigned CTRL_SCAN_BIT = 5;
   localparam logic [7:0] CTRL_WMASK = 8'h3f;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [1:0] PHASE_FIRST = 2'h0;
   localparam logic [1:0] PHASE_STEP = 2'h1;
   localparam logic [1:0] SLOTS_STATIC = 2'h0;

   // ==========================================================
   // types
   typedef enum logic [1:0] {
      bias_static = 2'h0,
      bias_half = 2'h1,
      bias_third = 2'h2
   } lcdsd_bias_t;

   // pin level codes; logic_* are plain cmos levels used only in key scan
   typedef enum logic [2:0] {
      rail_gnd = 3'h0,
      lcd_rail_mid_b = 3'h1,
      lcd_rail_mid_a = 3'h2,
      lcd_rail_high = 3'h3,
      logic_low = 3'h4,
      logic_high = 3'h5
   } lcdsd_rail_t;

   typedef enum logic [1:0] {
      seq_idle = 2'b00,
      seq_disp = 2'b01,
      seq_scan_a = 2'b11,
      seq_scan_b = 2'b10
   } lcdsd_seq_t;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } lcdsd_bus_req_t;

   typedef logic [DMEM_BYTES-1:0][7:0] lcdsd_dmem_t;

   // ==========================================================
   // functions
   // static only exists with one slot; a bias of static with more slots runs as half
   function automatic lcdsd_bias_t lcdsd_eff_bias(input logic [1:0] slots_m1,
                                                  input logic [1:0] bias);
      if (slots_m1 == SLOTS_STATIC)
         return bias_static;
      else if (bias == bias_third)
         return bias_third;
      else
         return bias_half;
   endfunction

   // pol flips every frame, so the pair of levels seen over two frames is balanced
   function automatic lcdsd_rail_t lcdsd_level(input lcdsd_bias_t bias, input logic pol,
                                               input logic is_com, input logic sel);
      lcdsd_rail_t swing_a;
      lcdsd_rail_t swing_b;
      swing_a = pol ? rail_gnd : lcd_rail_high;
      swing_b = pol ? lcd_rail_high : rail_gnd;
      if (is_com)
      begin
         if (sel || bias == bias_static)
            return swing_a;
         else if (bias == bias_half)
            return lcd_rail_mid_a;
         else
            return pol ? lcd_rail_mid_a : lcd_rail_mid_b;
      end
      else if (sel)
         return swing_b;
      else if (bias == bias_third)
         // off cells see a third of the drive, never two thirds
         return pol ? lcd_rail_mid_b : lcd_rail_mid_a;
      else
         return swing_a;
   endfunction

   function automatic lcdsd_rail_t lcdsd_scan_pin(input logic [7:0] port,
                                                  input logic second, input logic [1:0] k);
      logic [3:0] nib;
      nib = second ? port[7:4] : port[3:0];
      return nib[k] ? logic_high : logic_low;
   endfunction

endpackage

// file: hdl/lcdsd_slot_tick.sv
// slot-rate enable divider of the segment lcd driver
`timescale 1ns/100ps
module lcdsd_slot_tick import lcdsd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // control
   input wire logic run,
   // slot enable pulse
   output logic tick
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [SLOT_CNT_W-1:0] cnt;
   } lcdsd_tick_state_t;

   lcdsd_tick_state_t st_ff;
   lcdsd_tick_state_t nxt_st;

   assign tick = run && (st_ff.cnt == SLOT_LAST);

   always_comb
   begin
      nxt_st = st_ff;
      if (!run || tick)
         nxt_st.cnt = SLOT_CNT_RESET;
      else
         nxt_st.cnt = SLOT_CNT_W'(st_ff.cnt + 1'b1);
   end

   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         st_ff <= '{cnt: SLOT_CNT_RESET};
      else
         st_ff <= nxt_st;
   end

endmodule

// file: hdl/lcdsd_top.sv
// segment lcd driver: register port, slot sequencer and pin level generation
//
// How it works
// [R1] display period segments come from 32 memory bytes at fa40h..fa5fh, one each
// [R2] byte bit n is used during common phase n, n from 0 to 3
// [R3] memory bit 1 drives select level, bit 0 deselect level, segments 0..31
// [R4] key scan period takes segment values from scan port registers 14 and 15
// [R5] scan port bits 0..3 in the first half, bits 4..7 in the second
// [R6] scan period drives segments 24..31 as plain high or low logic levels
// [R7] memory bits above the slot count are ignored and free for software; the code clears bits 4..7 of fa40h..fa43h on write instead
// [R8] upper nibble of bytes fa40h..fa43h is fixed zero on write and read
// [R9] segment is on only when segment and common both sit at select level
// [R10] static: common swings high rail to ground, segment opposite or same phase
// [R11] half bias: selected common swings, deselected common sits at mid rail
// [R12] third bias: deselected common and segment use mid rails in opposite order
// [R13] all drive levels reverse polarity every frame to cancel dc
`timescale 1ns/100ps
module lcdsd_top import lcdsd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register port
   input wire lcdsd_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   // common electrodes
   output lcdsd_rail_t common_line_0,
   output lcdsd_rail_t common_line_1,
   output lcdsd_rail_t common_line_2,
   output lcdsd_rail_t common_line_3,
   // segment electrodes, [0] is segment_output_first, [31] segment_output_last
   output lcdsd_rail_t [SEGMENTS-1:0] segment_output,
   // key scan period flag
   output logic scan_period
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] scan_port_a;
      logic [7:0] scan_port_b;
      logic [7:0] rdata;
      lcdsd_seq_t seq;
      logic [1:0] phase;
      logic pol;
      lcdsd_rail_t [COMMONS-1:0] com;
      lcdsd_rail_t [SEGMENTS-1:0] seg;
   } lcdsd_top_state_t;

   lcdsd_top_state_t st_ff;
   lcdsd_top_state_t nxt_st;

   logic tick;
   logic run;
   logic scan_en;
   logic [1:0] slots_m1;
   lcdsd_bias_t bias;
   logic in_dmem;
   logic dmem_wr;
   logic [DMEM_IDX_W-1:0] dmem_idx;
   logic [7:0] dmem_rd;
   lcdsd_dmem_t dmem_q;
   logic [7:0] status;

   // ==========================================================
   // control decode
   assign run = st_ff.ctrl[CTRL_EN_BIT];
   assign scan_en = st_ff.ctrl[CTRL_SCAN_BIT];
   assign slots_m1 = st_ff.ctrl[CTRL_SLOTS_LSB +: CTRL_SLOTS_W];
   assign bias = lcdsd_eff_bias(slots_m1, st_ff.ctrl[CTRL_BIAS_LSB +: CTRL_BIAS_W]);
   assign in_dmem = (bus_req.addr >= DMEM_BASE) && (bus_req.addr <= DMEM_LAST); // see [R1]
   assign dmem_idx = DMEM_IDX_W'(bus_req.addr - DMEM_BASE);
   assign dmem_wr = bus_req.wr && in_dmem;
   assign status = {3'h0, st_ff.seq != seq_idle, st_ff.seq[1], st_ff.pol, st_ff.phase};

   // ==========================================================
   // leaves
   lcdsd_slot_tick u_tick
   (
      .clock(clock),
      .reset_n(reset_n),
      .run(run),
      .tick(tick)
   );

   lcdsd_dispmem u_dmem
   (
      .clock(clock),
      .reset_n(reset_n),
      .wr_en(dmem_wr),
      .wr_index(dmem_idx),
      .wr_data(bus_req.wdata),
      .rd_index(dmem_idx),
      .rd_data(dmem_rd),
      .mem_q(dmem_q)
   );

   // ==========================================================
   // next state
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.rdata = REG_RESET;

      // register writes
      if (bus_req.wr)
      begin
         unique case (bus_req.addr)
            CTRL_ADDR: nxt_st.ctrl = bus_req.wdata & CTRL_WMASK;
            SCAN_PORT_A_ADDR: nxt_st.scan_port_a = bus_req.wdata;
            SCAN_PORT_B_ADDR: nxt_st.scan_port_b = bus_req.wdata;
            default: ;
         endcase
      end

      // register reads; unmapped addresses answer zero
      if (bus_req.rd)
      begin
         if (in_dmem)
            nxt_st.rdata = dmem_rd;
         else
         begin
            unique case (bus_req.addr)
               CTRL_ADDR: nxt_st.rdata = st_ff.ctrl;
               SCAN_PORT_A_ADDR: nxt_st.rdata = st_ff.scan_port_a;
               SCAN_PORT_B_ADDR: nxt_st.rdata = st_ff.scan_port_b;
               STATUS_ADDR: nxt_st.rdata = status;
               default: nxt_st.rdata = REG_RESET;
            endcase
         end
      end

      // slot sequencer; mode changes take effect at the next slot edge, but clearing the enable stops it at the next clock
      if (!run)
      begin
         nxt_st.seq = seq_idle;
         nxt_st.phase = PHASE_FIRST;
         nxt_st.pol = 1'b0;
      end
      else if (tick)
      begin
         unique case (st_ff.seq)
            seq_idle:
            begin
               nxt_st.seq = seq_disp;
               nxt_st.phase = PHASE_FIRST;
            end
            seq_disp:
            begin
               // phase never passes the slot count, so unused bits stay unread
               if (st_ff.phase >= slots_m1) // see [R7]
               begin
                  nxt_st.phase = PHASE_FIRST;
                  nxt_st.pol = ~st_ff.pol; // see [R13]
                  if (scan_en)
                     nxt_st.seq = seq_scan_a; // see [R4]
               end
               else
                  nxt_st.phase = 2'(st_ff.phase + PHASE_STEP); // see [R2]
            end
            seq_scan_a: nxt_st.seq = seq_scan_b; // see [R5]
            seq_scan_b: nxt_st.seq = seq_disp;
         endcase
      end

      // pin levels, registered and recomputed every clock, so memory and control writes reach the pins one clock later
      for (int c = 0; c < COMMONS; c++)
      begin
         if (nxt_st.seq != seq_disp || 2'(c) > slots_m1)
            nxt_st.com[c] = rail_gnd;
         else
            // see [R10] [R11] [R12]
            nxt_st.com[c] = lcdsd_level(bias, nxt_st.pol, 1'b1, 2'(c) == nxt_st.phase);
      end
      for (int i = 0; i < SEGMENTS; i++)
      begin
         if (nxt_st.seq == seq_disp)
            // see [R3] [R9]
            nxt_st.seg[i] = lcdsd_level(bias, nxt_st.pol, 1'b0, dmem_q[i][nxt_st.phase]);
         else if (nxt_st.seq[1] && i >= SCAN_FIRST)
            nxt_st.seg[i] = lcdsd_scan_pin((i < SCAN_SPLIT) ? st_ff.scan_port_a
                                                             : st_ff.scan_port_b,
                                           nxt_st.seq == seq_scan_b,
                                           2'(i - SCAN_FIRST)); // see [R6]
         else
            nxt_st.seg[i] = rail_gnd;
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         st_ff <= '{ctrl: REG_RESET, scan_port_a: REG_RESET, scan_port_b: REG_RESET,
                    rdata: REG_RESET, seq: seq_idle, phase: PHASE_FIRST, pol: 1'b0,
                    com: '{default: rail_gnd}, seg: '{default: rail_gnd}};
      else
         st_ff <= nxt_st;
   end

   // ==========================================================
   // outputs
   assign bus_rdata = st_ff.rdata;
   assign common_line_0 = st_ff.com[0];
   assign common_line_1 = st_ff.com[1];
   assign common_line_2 = st_ff.com[2];
   assign common_line_3 = st_ff.com[3];
   assign segment_output = st_ff.seg;
   assign scan_period = st_ff.seq[1];

endmodule

// file: test/lcdsd_panel.sv
// lcd glass model: one cell per common and segment pair
`timescale 1ns/100ps
module lcdsd_panel import lcdsd_pkg::*;
(
   // rear electrodes
   input wire lcdsd_rail_t common_line_0,
   input wire lcdsd_rail_t common_line_1,
   input wire lcdsd_rail_t common_line_2,
   input wire lcdsd_rail_t common_line_3,
   // front electrodes
   input wire lcdsd_rail_t [SEGMENTS-1:0] segment_output,
   // lit cells
   output logic [3:0][SEGMENTS-1:0] lit
);
   lcdsd_rail_t com [4];
   assign com = '{common_line_0, common_line_1, common_line_2, common_line_3};
   // ==========================================================
   // only a full swing lights a cell; mid rails stay dark
   always_comb
      for (int c = 0; c < 4; c++)
         for (int s = 0; s < SEGMENTS; s++)
            lit[c][s] = (com[c] == lcd_rail_high && segment_output[s] == rail_gnd) ||
               (com[c] == rail_gnd && segment_output[s] == lcd_rail_high);
endmodule

// file: test/lcdsd_top_asserts.sv
// assertion checker of the segment lcd driver
`timescale 1ns/100ps
module lcdsd_top_asserts import lcdsd_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register port
   input wire lcdsd_bus_req_t bus_req,
   input wire logic [7:0] bus_rdata,
   // pins
   input wire lcdsd_rail_t common_line_0,
   input wire lcdsd_rail_t common_line_1,
   input wire lcdsd_rail_t common_line_2,
   input wire lcdsd_rail_t common_line_3,
   input wire lcdsd_rail_t [SEGMENTS-1:0] segment_output,
   input wire logic scan_period
);
   logic scan_ok;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // helper
   always_comb
   begin
      scan_ok = 1'b1;
      for (int i = SCAN_FIRST; i < SEGMENTS; i++)
         if (segment_output[i] < logic_low)
            scan_ok = 1'b0;
   end
   // ==========================================================
   // properties
   property p_rd_idle;
      !$past(bus_req.rd) |-> bus_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_nib_zero;
      bus_req.rd && bus_req.addr >= DMEM_BASE && bus_req.addr <= DMEM_BASE + 16'h0003
         |=> bus_rdata[7:4] == 4'h0;
   endproperty
   a_nib_zero: assert property (p_nib_zero) else $error("upper nibble not zero");
   property p_scan_logic;
      scan_period |-> scan_ok;
   endproperty
   a_scan_logic: assert property (p_scan_logic) else $error("scan pin not logic");
   property p_scan_gnd;
      scan_period |-> common_line_0 == rail_gnd && segment_output[0] == rail_gnd;
   endproperty
   a_scan_gnd: assert property (p_scan_gnd) else $error("lcd drive in scan");
   property p_disp_lcd;
      !scan_period |-> segment_output[SEGMENTS-1] < logic_low;
   endproperty
   a_disp_lcd: assert property (p_disp_lcd) else $error("logic level in display");
   // a control write may stop the sequencer at once, so it ends the attempt
   property p_hold;
      disable iff (!reset_n || (bus_req.wr && bus_req.addr == CTRL_ADDR))
      $changed(common_line_0) |=> $stable(common_line_0) [*8];
   endproperty
   a_hold: assert property (p_hold) else $error("common level too short");
   property p_scan_len;
      disable iff (!reset_n || (bus_req.wr && bus_req.addr == CTRL_ADDR))
      $rose(scan_period) |-> scan_period [*8];
   endproperty
   a_scan_len: assert property (p_scan_len) else $error("scan half too short");
   property p_third;
      common_line_0 == lcd_rail_mid_b |-> segment_output[0] != lcd_rail_mid_b;
   endproperty
   a_third: assert property (p_third) else $error("mid rails in same order");
   c_scan: cover property ($rose(scan_period));
   c_mid: cover property (common_line_1 == lcd_rail_mid_a);
   c_nib: cover property (bus_req.rd && bus_req.addr == DMEM_BASE);
endmodule

bind lcdsd_top lcdsd_top_asserts lcdsd_top_asserts_i
(
   .clock(clock),
   .reset_n(reset_n),
   .bus_req(bus_req),
   .bus_rdata(bus_rdata),
   .common_line_0(common_line_0),
   .common_line_1(common_line_1),
   .common_line_2(common_line_2),
   .common_line_3(common_line_3),
   .segment_output(segment_output),
   .scan_period(scan_period)
);

// file: test/lcdsd_top_bench.sv
// self-checking bench of the segment lcd driver
`timescale 1ns/100ps
module lcdsd_top_bench import lcdsd_pkg::*;
;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   lcdsd_bus_req_t bus_req = '0;
   logic [7:0] bus_rdata;
   lcdsd_rail_t c0, c1, c2, c3;
   lcdsd_rail_t [SEGMENTS-1:0] seg;
   logic scan_period;
   logic [3:0][SEGMENTS-1:0] lit;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   always #5 clock = ~clock;
   lcdsd_top lcdsd_top_i (.clock(clock), .reset_n(reset_n), .bus_req(bus_req),
      .bus_rdata(bus_rdata), .common_line_0(c0), .common_line_1(c1), .common_line_2(c2),
      .common_line_3(c3), .segment_output(seg), .scan_period(scan_period));
   lcdsd_panel lcdsd_panel_i (.common_line_0(c0), .common_line_1(c1), .common_line_2(c2),
      .common_line_3(c3), .segment_output(seg), .lit(lit));
   // ==========================================================
   // helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      bus_req <= '0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus_req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus_req <= '0;
      #1;
      chk(bus_rdata, exp);
   endtask
   // pins are sampled at falling edges, well clear of updates, apart from the first scan check after rd
   task automatic slot();
      repeat (SLOT_CYCLES) @(negedge clock);
   endtask
   task automatic go(input logic [7:0] ctrl);
      int n;
      wr(CTRL_ADDR, 8'h00);
      wr(CTRL_ADDR, ctrl);
      n = 0;
      while (c0 !== lcd_rail_high && n < 1100)
      begin
         @(negedge clock);
         n++;
      end
      chk(c0, lcd_rail_high);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs();
      wr(DMEM_BASE, 8'hff);
      wr(DMEM_BASE + 16'h0004, 8'ha5);
      rd(DMEM_BASE, 8'h0f);
      rd(DMEM_BASE + 16'h0004, 8'ha5);
      rd(16'h1234, 8'h00);
      $display("regs done");
   endtask
   task automatic t_static();
      wr(DMEM_BASE, 8'h0e);
      wr(DMEM_BASE + 16'h0005, 8'h01);
      go(8'h10);
      chk(seg[0], lcd_rail_high);
      chk(seg[5], rail_gnd);
      chk(lit[0][5], 1'b1);
      chk(lit[0][0], 1'b0);
      slot();
      chk(c0, rail_gnd);
      chk(seg[5], lcd_rail_high);
      chk(seg[0], rail_gnd);
      $display("static done");
   endtask
   task automatic t_half();
      wr(DMEM_BASE + 16'h0002, 8'h02);
      go(8'h15);
      chk(c1, lcd_rail_mid_a);
      chk(seg[2], lcd_rail_high);
      slot();
      chk(c1, lcd_rail_high);
      chk(c0, lcd_rail_mid_a);
      chk(seg[2], rail_gnd);
      chk(lit[1][2], 1'b1);
      $display("half done");
   endtask
   // first frame: selected common high, so off commons sit low-mid, off segments high-mid
   task automatic t_third();
      wr(DMEM_BASE + 16'h0001, 8'h0a);
      go(8'h1a);
      chk(c3, rail_gnd);
      chk(seg[1], lcd_rail_mid_a);
      chk(c1, lcd_rail_mid_b);
      chk(c2, lcd_rail_mid_b);
      slot();
      chk(seg[1], rail_gnd);
      repeat (3) slot();
      chk(c1, rail_gnd);
      chk(c0, lcd_rail_mid_a);
      chk(seg[1], lcd_rail_high);
      $display("third done");
   endtask
   task automatic t_scan();
      logic [7:0] v;
      wr(SCAN_PORT_A_ADDR, 8'h5a);
      wr(SCAN_PORT_B_ADDR, 8'hc3);
      go(8'h30);
      slot();
      chk(scan_period, 1'b1);
      chk(c0, rail_gnd);
      chk(seg[0], rail_gnd);
      rd(CTRL_ADDR, 8'h30);
      rd(STATUS_ADDR, 8'h1c);
      v = 8'h3a;
      repeat (2)
      begin
         for (int j = 0; j < 8; j++)
            chk(seg[SCAN_FIRST + j], v[j] ? logic_high : logic_low);
         slot();
         v = 8'hc5;
      end
      chk(scan_period, 1'b0);
      chk(c0, rail_gnd);
      $display("scan done");
   endtask
   // ==========================================================
   // run
   task automatic conclude();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // whole run is about 13000 cycles, so this only trips on a hang
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         conclude();
      end
   end
   initial
   begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      t_regs();
      t_static();
      t_half();
      t_third();
      t_scan();
      conclude();
   end
endmodule
